// >>> rtl/pcs_status_class_regs.sv
// status, command-enable and class/revision configuration registers of the link function
`timescale 1ns/1ps
`include "pcs_consts.svh"

module pcs_status_class_regs #(
    // arbitrary value, replaced per silicon step
    parameter logic [7:0] SILICON_REVISION = 8'h5A
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire pcs_pkg::pcs_addr_t cfg_addr,
    input wire pcs_pkg::pcs_be_t cfg_be,
    input wire pcs_pkg::pcs_word_t cfg_wdata,
    output pcs_pkg::pcs_word_t cfg_rdata,
    output logic cfg_ack,
    input wire logic addr_parity_err,
    input wire logic data_parity_err,
    input wire logic perr_seen,
    input wire logic master_active,
    input wire logic master_abort_evt,
    input wire logic target_abort_rcvd,
    input wire logic target_abort_sent,
    output logic serr_pulse,
    output logic perr_pulse,
    output logic [1:0] devsel_timing
);
    import pcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic dw_hit(input pcs_addr_t a, input pcs_addr_t off);
        dw_hit = (a[7:2] == off[7:2]);
    endfunction

    pcs_half_t status_r;
    pcs_half_t status_nxt;
    logic perr_en_r;
    logic perr_en_nxt;
    logic serr_en_r;
    logic serr_en_nxt;
    pcs_word_t rdata_r;
    pcs_word_t rdata_nxt;
    logic ack_r;
    logic serr_r;
    logic perr_r;
    logic [1:0] devsel_r;

    wire hit_cmd = dw_hit(cfg_addr, `PCS_CMD_OFF);
    wire hit_class = dw_hit(cfg_addr, `PCS_CLASS_OFF);
    wire wr_cmd = cfg_req && cfg_we && hit_cmd;

    // status shares the dword with command; upper two lanes carry it
    wire pcs_half_t clr_mask = wr_cmd ? ({cfg_be[3] ? cfg_wdata[31:24] : 8'h00,
                                          cfg_be[2] ? cfg_wdata[23:16] : 8'h00}
                                         & `PCS_STATUS_CLR_MASK) : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // event sources

    // system error only with its driver enabled
    wire serr_fire = addr_parity_err && serr_en_r;
    wire dpar_set = perr_seen && master_active && perr_en_r;
    wire perr_fire = data_parity_err && perr_en_r;

    pcs_half_t set_vec;
    always_comb
    begin
        set_vec = 16'h0000;
        set_vec[`PCS_ST_PAR_BIT] = addr_parity_err || data_parity_err;
        set_vec[`PCS_ST_SERR_BIT] = serr_fire;
        set_vec[`PCS_ST_RECEIVED_MASTER_ABORT_BIT] = master_abort_evt;
        set_vec[`PCS_ST_TAREC_BIT] = target_abort_rcvd;
        set_vec[`PCS_ST_TASIG_BIT] = target_abort_sent;
        set_vec[`PCS_ST_DPAR_BIT] = dpar_set;
    end

    // set wins over a clear in the same cycle
    assign status_nxt = (set_vec | (status_r & ~clr_mask)) & `PCS_STATUS_CLR_MASK;

    assign perr_en_nxt = (wr_cmd && cfg_be[0]) ? cfg_wdata[`PCS_CMD_PERR_EN_BIT] : perr_en_r;
    assign serr_en_nxt = (wr_cmd && cfg_be[1]) ? cfg_wdata[`PCS_CMD_SERR_EN_BIT] : serr_en_r;

    ////////////////////////////////////////////////////////////////////////////
    // read view

    // hardwired fields are never stored, so no write can reach them
    wire pcs_half_t status_view = {status_r[15:11], `PCS_DEVSEL_MEDIUM,
                                   status_r[`PCS_ST_DPAR_BIT],
                                   `PCS_FAST_B2B_CAPABLE,
                                   `PCS_UDF_SUP,
                                   `PCS_DBL_SPEED,
                                   `PCS_CAP_LIST,
                                   `PCS_ST_RSVD};

    wire pcs_half_t cmd_view = {7'h00, serr_en_r, 1'b0, perr_en_r, 6'h00};

    wire pcs_word_t class_view = {`PCS_BASE_CLASS,
                                  `PCS_SUB_CLASS,
                                  `PCS_PROG_IF,
                                  SILICON_REVISION};

    // writes to the class dword decode to nothing: read-only
    assign rdata_nxt = (!cfg_req || cfg_we) ? 32'h0000_0000 :
                       hit_cmd ? {status_view, cmd_view} :
                       hit_class ? class_view : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // state

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_r <= `PCS_STATUS_RST & `PCS_STATUS_CLR_MASK;
            perr_en_r <= `PCS_CMD_EN_RST;
            serr_en_r <= `PCS_CMD_EN_RST;
        end
        else if (ce)
        begin
            status_r <= status_nxt;
            perr_en_r <= perr_en_nxt;
            serr_en_r <= serr_en_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            serr_r <= 1'b0;
            perr_r <= 1'b0;
            devsel_r <= 2'h0;
        end
        else if (ce)
        begin
            rdata_r <= rdata_nxt;
            ack_r <= cfg_req;
            serr_r <= serr_fire;
            perr_r <= perr_fire;
            devsel_r <= `PCS_DEVSEL_MEDIUM;
        end
    end

    assign cfg_rdata = rdata_r;
    assign cfg_ack = ack_r;
    assign serr_pulse = serr_r;
    assign perr_pulse = perr_r;
    assign devsel_timing = devsel_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_par_flag_set: assert property (@(posedge clk) disable iff (rst)
        ce && (addr_parity_err || data_parity_err) |=> status_r[15])
        else $error("parity flag not set");

    a_serr_flag_gate: assert property (@(posedge clk) disable iff (rst)
        ce && $rose(status_r[14]) |-> $past(addr_parity_err) && $past(serr_en_r))
        else $error("system error flag set without cause");

    a_received_master_abort_set: assert property (@(posedge clk) disable iff (rst)
        ce && master_abort_evt |=> status_r[13])
        else $error("master abort flag not set");

    a_tarec_set: assert property (@(posedge clk) disable iff (rst)
        ce && target_abort_rcvd |=> status_r[12])
        else $error("received target abort flag not set");

    a_tasig_set: assert property (@(posedge clk) disable iff (rst)
        ce && target_abort_sent |=> status_r[11])
        else $error("signalled target abort flag not set");

    a_dpar_cause: assert property (@(posedge clk) disable iff (rst)
        ce && !status_r[8] ##1 status_r[8] |-> $past(perr_seen) && $past(master_active) && $past(perr_en_r))
        else $error("data parity flag set without all three conditions");

    a_clear_one: assert property (@(posedge clk) disable iff (rst)
        ce && wr_cmd && cfg_be[3] && cfg_wdata[29] && !master_abort_evt |=> !status_r[13])
        else $error("write one did not clear flag");

    a_sticky_flag: assert property (@(posedge clk) disable iff (rst)
        ce && status_r[15] && !(wr_cmd && cfg_be[3] && cfg_wdata[31]) |=> status_r[15])
        else $error("flag dropped without a clear");

    a_set_wins: assert property (@(posedge clk) disable iff (rst)
        ce && master_abort_evt && wr_cmd && cfg_be[3] && cfg_wdata[29] |=> status_r[13])
        else $error("clear beat a simultaneous set");

    a_status_fixed: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_cmd |=> {cfg_rdata[26:25], cfg_rdata[23:16]} == 10'h110)
        else $error("hardwired status bits wrong");

    a_class_read: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_class |=> cfg_ack && cfg_rdata == {24'h0C_0010, SILICON_REVISION})
        else $error("class code read wrong");

    a_serr_pulse: assert property (@(posedge clk) disable iff (rst)
        ce && serr_pulse |-> $past(addr_parity_err) && $past(serr_en_r))
        else $error("system error pulse without enable");

    a_perr_pulse: assert property (@(posedge clk) disable iff (rst)
        ce && data_parity_err && perr_en_r |=> perr_pulse)
        else $error("parity response pulse missing");

    a_devsel_medium: assert property (@(posedge clk) disable iff (rst)
        $past(ce) && !$past(rst) |-> devsel_timing == 2'h1)
        else $error("select timing not medium");

    ////////////////////////////////////////////////////////////////////////////
    // bus answer and hardwired fields, one field per check so a failure names it

    a_ack_follows: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req |=> cfg_ack)
        else $error("request not acknowledged");

    a_ack_only_req: assert property (@(posedge clk) disable iff (rst)
        ce && !cfg_req |=> !cfg_ack)
        else $error("acknowledge without request");

    a_write_rdata: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && cfg_we |=> cfg_rdata == 32'h0000_0000)
        else $error("write returned read data");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && !cfg_we && !hit_cmd && !hit_class |=> cfg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_rsvd_bits: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_cmd |=> cfg_rdata[19:16] == 4'h0)
        else $error("reserved status bits not zero");

    a_capability_list_present_one: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_cmd |=> cfg_rdata[20])
        else $error("capability list bit not one");

    a_fbb_zero: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_cmd |=> !cfg_rdata[23])
        else $error("fast back to back bit not zero");

    a_udf_zero: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_cmd |=> !cfg_rdata[22])
        else $error("user feature bit not zero");

    a_dbl_speed: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_cmd |=> !cfg_rdata[21])
        else $error("double speed bit not zero");

    a_devsel_field: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_cmd |=> cfg_rdata[26:25] == 2'h1)
        else $error("select timing field wrong");

    a_cmd_view: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_cmd |=> (cfg_rdata[15:0] & 16'hFEBF) == 16'h0000)
        else $error("unkept command bits not zero");

    ////////////////////////////////////////////////////////////////////////////
    // flag causes: a flag rises for its own event and only for it; the error pulses likewise

    a_serr_sets: assert property (@(posedge clk) disable iff (rst)
        ce && addr_parity_err && serr_en_r |=> status_r[14])
        else $error("system error flag not set");

    a_serr_needs_en: assert property (@(posedge clk) disable iff (rst)
        ce && !status_r[14] && !(addr_parity_err && serr_en_r) |=> !status_r[14])
        else $error("system error flag set without enable");

    a_dpar_sets: assert property (@(posedge clk) disable iff (rst)
        ce && perr_seen && master_active && perr_en_r |=> status_r[8])
        else $error("data parity flag not set");

    a_dpar_blocked: assert property (@(posedge clk) disable iff (rst)
        ce && !status_r[8] && !(perr_seen && master_active && perr_en_r) |=> !status_r[8])
        else $error("data parity flag set without cause");

    a_par_quiet: assert property (@(posedge clk) disable iff (rst)
        ce && !status_r[15] && !addr_parity_err && !data_parity_err |=> !status_r[15])
        else $error("parity flag set without cause");

    a_received_master_abort_quiet: assert property (@(posedge clk) disable iff (rst)
        ce && !status_r[13] && !master_abort_evt |=> !status_r[13])
        else $error("master abort flag set without cause");

    a_tarec_quiet: assert property (@(posedge clk) disable iff (rst)
        ce && !status_r[12] && !target_abort_rcvd |=> !status_r[12])
        else $error("received target abort flag set without cause");

    a_tasig_quiet: assert property (@(posedge clk) disable iff (rst)
        ce && !status_r[11] && !target_abort_sent |=> !status_r[11])
        else $error("signalled target abort flag set without cause");

    a_perr_quiet: assert property (@(posedge clk) disable iff (rst)
        ce && !(data_parity_err && perr_en_r) |=> !perr_pulse)
        else $error("parity response pulse without cause");

    a_serr_quiet: assert property (@(posedge clk) disable iff (rst)
        ce && !(addr_parity_err && serr_en_r) |=> !serr_pulse)
        else $error("system error pulse without cause");

    ////////////////////////////////////////////////////////////////////////////
    // clears, enables and freeze

    a_clear_tasig: assert property (@(posedge clk) disable iff (rst)
        ce && wr_cmd && cfg_be[3] && cfg_wdata[27] && !target_abort_sent |=> !status_r[11])
        else $error("write one did not clear target abort flag");

    a_zero_keeps: assert property (@(posedge clk) disable iff (rst)
        ce && status_r[13] && !(wr_cmd && cfg_be[3] && cfg_wdata[29]) |=> status_r[13])
        else $error("flag dropped by a zero write");

    a_perr_en_write: assert property (@(posedge clk) disable iff (rst)
        ce && wr_cmd && cfg_be[0] |=> perr_en_r == $past(cfg_wdata[6]))
        else $error("parity response enable not written");

    a_serr_en_write: assert property (@(posedge clk) disable iff (rst)
        ce && wr_cmd && cfg_be[1] |=> serr_en_r == $past(cfg_wdata[8]))
        else $error("system error enable not written");

    a_freeze_flags: assert property (@(posedge clk) disable iff (rst)
        !ce |=> $stable(status_r))
        else $error("flags moved with clock enable low");

    a_freeze_ack: assert property (@(posedge clk) disable iff (rst)
        !ce |=> $stable(cfg_ack))
        else $error("acknowledge moved with clock enable low");

endmodule

// >>> rtl/pcs_consts.svh
// offsets, field positions, reset values and fixed codes of the status and class registers
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

`define PCS_CMD_OFF 8'h04
`define PCS_STATUS_OFF 8'h06
`define PCS_CLASS_OFF 8'h08

`define PCS_CMD_PERR_EN_BIT 6
`define PCS_CMD_SERR_EN_BIT 8
`define PCS_CMD_RST 16'h0000
`define PCS_CMD_EN_RST 1'h0

`define PCS_ST_PAR_BIT 15
`define PCS_ST_SERR_BIT 14
`define PCS_ST_RECEIVED_MASTER_ABORT_BIT 13
`define PCS_ST_TAREC_BIT 12
`define PCS_ST_TASIG_BIT 11
`define PCS_ST_DPAR_BIT 8
`define PCS_STATUS_RST 16'h0210
`define PCS_STATUS_CLR_MASK 16'hF900

`define PCS_DEVSEL_MEDIUM 2'h1
`define PCS_FAST_B2B_CAPABLE 1'h0
`define PCS_UDF_SUP 1'h0
`define PCS_DBL_SPEED 1'h0
`define PCS_CAP_LIST 1'h1
`define PCS_ST_RSVD 4'h0

`define PCS_BASE_CLASS 8'h0C
`define PCS_SUB_CLASS 8'h00
`define PCS_PROG_IF 8'h10

`endif

// >>> rtl/pcs_pkg.sv
// types shared by the status and class register block
package pcs_pkg;
    typedef logic [7:0] pcs_addr_t;
    typedef logic [31:0] pcs_word_t;
    typedef logic [3:0] pcs_be_t;
    typedef logic [15:0] pcs_half_t;
endpackage

// >>> test/pcs_host_model.sv
// host model issuing configuration reads and writes
`timescale 1ns/1ps
module pcs_host_model (
    input wire logic clk,
    output logic cfg_req,
    output logic cfg_we,
    output pcs_pkg::pcs_addr_t cfg_addr,
    output pcs_pkg::pcs_be_t cfg_be,
    output pcs_pkg::pcs_word_t cfg_wdata,
    input wire pcs_pkg::pcs_word_t cfg_rdata,
    input wire logic cfg_ack
);
    import pcs_pkg::*;
    initial
    begin
        cfg_req = 1'h0;
        cfg_we = 1'h0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end
    // released lines show inverted values so stale data never passes for a fresh request
    task automatic access(input logic we, input pcs_addr_t a, input pcs_be_t be, input pcs_word_t wd,
        output pcs_word_t rd);
        @(posedge clk);
        cfg_req <= 1'h1;
        cfg_we <= we;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= wd;
        @(posedge clk);
        cfg_req <= 1'h0;
        cfg_we <= ~we;
        cfg_addr <= ~a;
        cfg_be <= ~be;
        cfg_wdata <= ~wd;
        #1;
        rd = (cfg_ack === 1'h1) ? cfg_rdata : 'x;
    endtask
endmodule

// >>> test/tb_pci_status_class_code_regs.sv
// self-checking bench for the status and class register block
`timescale 1ns/1ps
module tb_pci_status_class_code_regs;
    import pcs_pkg::*;
    typedef struct {logic we; pcs_addr_t a; pcs_be_t be; pcs_word_t wd; pcs_word_t exp;} pcs_row_t;
    // arbitrary revision value
    localparam logic [7:0] REV = 8'h3C;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic [6:0] evt = 7'h00;
    logic cfg_req, cfg_we, cfg_ack, serr_pulse, perr_pulse;
    pcs_addr_t cfg_addr;
    pcs_be_t cfg_be;
    pcs_word_t cfg_wdata, cfg_rdata, rd;
    logic [1:0] devsel_timing;
    int err_count = 0;
    int checked = 0;
    pcs_row_t rows[7] = '{'{1'h0, 8'h08, 4'hF, 32'h0, {24'h0C0010, REV}},
        '{1'h1, 8'h08, 4'hF, 32'hFFFFFFFF, 32'h0}, '{1'h0, 8'h08, 4'hF, 32'h0, {24'h0C0010, REV}},
        '{1'h0, 8'h04, 4'hF, 32'h0, 32'h02100000}, '{1'h1, 8'h04, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'h0, 8'h06, 4'hF, 32'h0, 32'h02100140}, '{1'h0, 8'h0C, 4'hF, 32'h0, 32'h0}};
    logic [6:0] ev_tab[6] = '{7'h40, 7'h20, 7'h18, 7'h04, 7'h02, 7'h01};
    logic [15:0] st_tab[6] = '{16'hC000, 16'h8000, 16'h0100, 16'h2000, 16'h1000, 16'h0800};
    always #20 clk = ~clk;
    pcs_host_model host_u (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
    pcs_status_class_regs #(.SILICON_REVISION(REV)) dut_u (.clk(clk), .rst(rst), .ce(ce),
        .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .addr_parity_err(evt[6]), .data_parity_err(evt[5]),
        .perr_seen(evt[4]), .master_active(evt[3]), .master_abort_evt(evt[2]),
        .target_abort_rcvd(evt[1]), .target_abort_sent(evt[0]), .serr_pulse(serr_pulse),
        .perr_pulse(perr_pulse), .devsel_timing(devsel_timing));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input pcs_word_t exp, input pcs_word_t got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle event, then the registered error drivers are looked at in the cycle they stand
    task automatic pulse(input logic [6:0] e, input logic [1:0] ps);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= 7'h00;
        #1;
        chk("drivers", {30'h0, ps}, {30'h0, serr_pulse, perr_pulse});
    endtask
    task automatic complete_run();
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        foreach (rows[i])
        begin
            host_u.access(rows[i].we, rows[i].a, rows[i].be, rows[i].wd, rd);
            chk("row", rows[i].exp, rd);
        end
        chk("devsel", 32'h1, {30'h0, devsel_timing});
        for (int i = 0; i < 6; i++)
        begin
            pulse(ev_tab[i], {ev_tab[i][6], ev_tab[i][5]});
            host_u.access(1'h0, 8'h04, 4'hF, 32'h0, rd);
            chk("flag set", {16'h0210 | st_tab[i], 16'h0140}, rd);
            host_u.access(1'h1, 8'h04, 4'hC, {st_tab[i], 16'h0}, rd);
            host_u.access(1'h0, 8'h04, 4'hF, 32'h0, rd);
            chk("flag clear", 32'h02100140, rd);
        end
        host_u.access(1'h1, 8'h04, 4'h3, 32'h0, rd);
        pulse(7'h78, 2'h0);
        host_u.access(1'h0, 8'h04, 4'hF, 32'h0, rd);
        chk("enables off", 32'h82100000, rd);
        // clear of bits 15 and 13 lands with a new abort on bit 13
        fork
            host_u.access(1'h1, 8'h04, 4'hC, 32'hA0000000, rd);
            pulse(7'h04, 2'h0);
        join
        host_u.access(1'h1, 8'h04, 4'hC, 32'h0, rd);
        host_u.access(1'h0, 8'h04, 4'hF, 32'h0, rd);
        chk("set wins", 32'h22100000, rd);
        @(posedge clk);
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
        #1;
        chk("devsel in reset", 32'h0, {30'h0, devsel_timing});
        host_u.access(1'h0, 8'h04, 4'hF, 32'h0, rd);
        chk("after reset", 32'h02100000, rd);
        // an abort while the clock enable is low must leave no trace
        @(posedge clk);
        ce <= 1'h0;
        pulse(7'h04, 2'h0);
        @(posedge clk);
        ce <= 1'h1;
        host_u.access(1'h0, 8'h04, 4'hF, 32'h0, rd);
        chk("frozen", 32'h02100000, rd);
        complete_run();
    end
    initial
    begin
        #100000;
        err_count++;
        complete_run();
    end
endmodule
